/* src/ahp_pkg.sv */
package ahp_pkg;

   // ****************************************************************
   // Clock and timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 40;
   // Least times per programmed-I/O mode 0..4, in ns.
   localparam int PIO_SETUP_NS [5] = '{70, 50, 30, 30, 25};
   localparam int PIO_ACT_NS   [5] = '{165, 125, 100, 80, 70};
   localparam int PIO_CYCLE_NS [5] = '{600, 383, 240, 180, 120};
   localparam int UDMA_STOP_NS = 50;
   localparam logic [2:0] PIO_MODE_MAX = 3'h4;
   localparam logic [2:0] PIO_IORDY_MODE = 3'h3;
   localparam int CNT_W = 4;

   // Least time in ns to whole clock cycles, rounded up, never below one.
   function automatic logic [CNT_W-1:0] ahp_cyc_up(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      if (c < 1) begin
         c = 1;
      end
      return CNT_W'(c);
   endfunction

   localparam logic [CNT_W-1:0] UDMA_STOP_CYC = ahp_cyc_up(UDMA_STOP_NS);
   // Shortest strobe that still lets a negated ready through the synchroniser.
   localparam logic [CNT_W-1:0] IORDY_MIN_CYC = 4'h3;

   // ****************************************************************
   // Commands and states
   // ****************************************************************
   typedef enum logic [2:0] {
      OP_REG_RD  = 3'h0,
      OP_REG_WR  = 3'h1,
      OP_DAT_RD  = 3'h2,
      OP_DAT_WR  = 3'h3,
      OP_UDMA_IN = 3'h4,
      OP_UDMA_OUT = 3'h5
   } ahp_op_e;

   typedef enum logic [6:0] {
      ST_IDLE   = 7'h01,
      ST_SETUP  = 7'h02,
      ST_STROBE = 7'h04,
      ST_RECOV  = 7'h08,
      ST_UWAIT  = 7'h10,
      ST_URUN   = 7'h20,
      ST_USTOP  = 7'h40
   } ahp_state_e;

   // True for programmed-I/O operations that drive the data lines.
   function automatic logic ahp_is_write(input logic [2:0] op);
      return (op == OP_REG_WR) || (op == OP_DAT_WR);
   endfunction

   // True for 8-bit register operations.
   function automatic logic ahp_is_reg(input logic [2:0] op);
      return (op == OP_REG_RD) || (op == OP_REG_WR);
   endfunction

endpackage

/* src/ahp_sync.sv */
`timescale 1ns/10ps
// Two-stage synchroniser; the first stage is read by the second only.
module ahp_sync
   import ahp_pkg::*;
#(
   parameter int W = 1
) (
   input  wire logic         sys_clk,  // System clock.
   input  wire logic         nrst,     // Asynchronous reset, active low.
   input  wire logic [W-1:0] d,        // Asynchronous levels.
   output logic      [W-1:0] q         // Synchronised levels.
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] q_reg;

   // Both stages clear to zero so that the levels read as negated at reset.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         meta_reg <= '0;
         q_reg    <= '0;
      end else begin
         meta_reg <= d;
         q_reg    <= meta_reg;
      end
   end

   assign q = q_reg;

endmodule // ahp_sync

/* src/ahp_port.sv */
`timescale 1ns/10ps
// Overview of operation
// - Everything but the device reset output returns to idle while nrst low; that output is driven low.
// - Register bytes use only lower eight lines.
// - Data port transfers use full 16 bits.
// - Drive 3-bit address selecting target register.
// - First chip select low for command block.
// - Second chip select, active low, also drivable.
// - DMA acknowledge answers device DMA request.
// - Negated ready extends the current strobe.
// - Ready honoured from mode 3, optional below.
// - Read strobe fall lets device drive data.
// - Read data taken at read strobe rise.
// - Read strobe held low receiving Ultra DMA.
// - Read strobe toggles with Ultra DMA out words.
// - Write data held valid through strobe rise.
// - Separate active-low reset output for device.
module ahp_port
   import ahp_pkg::*;
(
   input  wire logic        sys_clk,                    // System clock, 25 MHz.
   input  wire logic        nrst,                       // Power-on reset, active low.
   input  wire logic        cmd_valid,                  // Command or burst word offered.
   output logic             cmd_ready,                  // Command taken this cycle, or burst word unless the burst ends this cycle.
   input  wire logic [2:0]  cmd_op,                     // Operation code.
   input  wire logic [2:0]  cmd_addr,                   // Target register address.
   input  wire logic        cmd_cs1,                    // Use second chip select.
   input  wire logic [15:0] cmd_wdata,                  // Write data.
   input  wire logic        udma_stop,                  // Request burst termination.
   input  wire logic [2:0]  pio_mode,                   // Programmed-I/O timing mode.
   input  wire logic        iordy_en,                   // Honour ready below mode 3.
   input  wire logic        dev_reset_req,              // Hold storage controller in reset.
   output logic             rsp_valid,                  // Read data pulse.
   output logic [15:0]      rsp_data,                   // Read data.
   output logic             busy,                       // Not idle.
   output logic             intrq_level,                // Synchronised interrupt request.
   output logic             dmarq_level,                // Synchronised DMA request.
   output logic [2:0]       da,                         // Device address.
   output logic             cs0_n,                      // Chip select 0.
   output logic             cs1_n,                      // Chip select 1.
   output logic             dior_n,                     // Read strobe / ready / strobe.
   output logic             diow_n,                     // Write strobe / stop.
   output logic             dmack_n,                    // DMA acknowledge.
   output logic             storage_controller_reset_n, // Storage controller reset.
   input  wire logic [15:0] dd_in,                      // Data bus input.
   output logic [15:0]      dd_out,                     // Data bus output.
   output logic             dd_oe,                      // Data bus drive enable.
   input  wire logic        iordy,                      // Ready / flow control / strobe.
   input  wire logic        intrq,                      // Interrupt request.
   input  wire logic        dmarq                       // DMA request.
);

   // ****************************************************************
   // Input synchronisation
   // ****************************************************************
   logic iordy_s;
   logic intrq_s;
   logic dmarq_s;

   // Pins are asynchronous to sys_clk, so each passes two flops.
   ahp_sync #(.W(3)) u_sync (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .d       ({iordy, intrq, dmarq}),
      .q       ({iordy_s, intrq_s, dmarq_s})
   );

   // ****************************************************************
   // Transfer sequencer
   // ****************************************************************
   ahp_state_e       state_reg,   state_next;
   logic [CNT_W-1:0] cnt_reg,     cnt_next;
   logic [2:0]       op_reg,      op_next;
   logic [2:0]       da_reg,      da_next;
   logic             cs0_reg,     cs0_next;
   logic             cs1_reg,     cs1_next;
   logic             dior_reg,    dior_next;
   logic             diow_reg,    diow_next;
   logic             dmack_reg,   dmack_next;
   logic [15:0]      dd_out_reg,  dd_out_next;
   logic             dd_oe_reg,   dd_oe_next;
   logic             rsp_v_reg,   rsp_v_next;
   logic [15:0]      rsp_d_reg,   rsp_d_next;
   logic             wpend_reg,   wpend_next;
   logic             dir_in_reg,  dir_in_next;
   logic             strb_d_reg,  strb_d_next;
   logic             rst_out_reg, rst_out_next;
   logic [2:0]       mode_idx;
   logic             honour;

   // Modes above the table use the fastest entry.
   assign mode_idx = (pio_mode > PIO_MODE_MAX) ? PIO_MODE_MAX : pio_mode;
   assign honour   = (mode_idx >= PIO_IORDY_MODE) || iordy_en;
   assign cmd_ready = (state_reg == ST_IDLE) ||
                      ((state_reg == ST_URUN) && !dir_in_reg && !wpend_reg);

   // Next state of the sequencer and of every pin it drives.
   always_comb begin
      state_next  = state_reg;
      cnt_next    = cnt_reg;
      op_next     = op_reg;
      da_next     = da_reg;
      cs0_next    = cs0_reg;
      cs1_next    = cs1_reg;
      dior_next   = dior_reg;
      diow_next   = diow_reg;
      dmack_next  = dmack_reg;
      dd_out_next = dd_out_reg;
      dd_oe_next  = dd_oe_reg;
      rsp_v_next  = 1'b0;
      rsp_d_next  = rsp_d_reg;
      wpend_next  = wpend_reg;
      dir_in_next = dir_in_reg;
      strb_d_next = iordy_s;
      case (state_reg)
         ST_IDLE: begin
            if (cmd_valid) begin
               op_next = cmd_op;
               da_next = cmd_addr;
               if ((cmd_op == OP_UDMA_IN) || (cmd_op == OP_UDMA_OUT)) begin
                  dir_in_next = (cmd_op == OP_UDMA_IN);
                  wpend_next  = 1'b0;
                  state_next  = ST_UWAIT;
               end else begin
                  cs0_next = cmd_cs1;
                  cs1_next = !cmd_cs1;
                  // Bytes ride the low lane; words use all lines.
                  dd_out_next = ahp_is_reg(cmd_op) ? {8'h00, cmd_wdata[7:0]} : cmd_wdata;
                  dd_oe_next  = ahp_is_write(cmd_op);
                  cnt_next    = ahp_cyc_up(PIO_SETUP_NS[mode_idx]);
                  state_next  = ST_SETUP;
               end
            end
         end
         ST_SETUP: begin
            if (cnt_reg <= 4'h1) begin
               // Read strobe fall hands the bus to the device.
               dior_next  = ahp_is_write(op_reg);
               diow_next  = !ahp_is_write(op_reg);
               cnt_next   = ahp_cyc_up(PIO_ACT_NS[mode_idx]);
               // Ready crosses two flops, so a short strobe would miss its negation.
               if (cnt_next < IORDY_MIN_CYC) begin
                  cnt_next = IORDY_MIN_CYC;
               end
               state_next = ST_STROBE;
            end else begin
               cnt_next = cnt_reg - 4'h1;
            end
         end
         ST_STROBE: begin
            if (cnt_reg > 4'h1) begin
               cnt_next = cnt_reg - 4'h1;
            end else if (!honour || iordy_s) begin
               dior_next = 1'b1;
               diow_next = 1'b1;
               // Data sampled in the last low cycle is what the rising edge latches.
               if (!ahp_is_write(op_reg)) begin
                  rsp_v_next = 1'b1;
                  rsp_d_next = ahp_is_reg(op_reg) ? {8'h00, dd_in[7:0]} : dd_in;
               end
               cnt_next   = ahp_cyc_up(PIO_CYCLE_NS[mode_idx] - PIO_SETUP_NS[mode_idx]
                                       - PIO_ACT_NS[mode_idx]);
               state_next = ST_RECOV;
            end
         end
         ST_RECOV: begin
            // Write data stays on the lines past the strobe rise.
            if (cnt_reg <= 4'h1) begin
               cs0_next   = 1'b1;
               cs1_next   = 1'b1;
               dd_oe_next = 1'b0;
               state_next = ST_IDLE;
            end else begin
               cnt_next = cnt_reg - 4'h1;
            end
         end
         ST_UWAIT: begin
            if (udma_stop) begin
               state_next = ST_IDLE;
            end else if (dmarq_s) begin
               dmack_next = 1'b0;
               diow_next  = 1'b0;
               dior_next  = !dir_in_reg;
               dd_oe_next = !dir_in_reg;
               state_next = ST_URUN;
            end
         end
         ST_URUN: begin
            if (udma_stop || !dmarq_s) begin
               dior_next  = 1'b1;
               diow_next  = 1'b1;
               dd_oe_next = 1'b0;
               wpend_next = 1'b0;
               cnt_next   = UDMA_STOP_CYC;
               state_next = ST_USTOP;
            end else if (dir_in_reg) begin
               // Each edge of the device strobe marks a new word.
               if (iordy_s != strb_d_reg) begin
                  rsp_v_next = 1'b1;
                  rsp_d_next = dd_in;
               end
            end else if (wpend_reg) begin
               // Strobe moves a cycle after the data, only while paced ready.
               if (!iordy_s) begin
                  dior_next  = !dior_reg;
                  wpend_next = 1'b0;
               end
            end else if (cmd_valid) begin
               dd_out_next = cmd_wdata;
               wpend_next  = 1'b1;
            end
         end
         ST_USTOP: begin
            if (cnt_reg <= 4'h1) begin
               dmack_next = 1'b1;
               diow_next  = 1'b1;
               state_next = ST_IDLE;
            end else begin
               cnt_next = cnt_reg - 4'h1;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // Reset output follows its request, and nrst drives it low; no bus cycle gates it.
   assign rst_out_next = !dev_reset_req;

   // Registers of the sequencer; all pins park inactive in reset except the storage controller reset, which is driven low.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_reg   <= ST_IDLE;
         cnt_reg     <= '0;
         op_reg      <= 3'h0;
         da_reg      <= 3'h0;
         cs0_reg     <= 1'b1;
         cs1_reg     <= 1'b1;
         dior_reg    <= 1'b1;
         diow_reg    <= 1'b1;
         dmack_reg   <= 1'b1;
         dd_out_reg  <= 16'h0000;
         dd_oe_reg   <= 1'b0;
         rsp_v_reg   <= 1'b0;
         rsp_d_reg   <= 16'h0000;
         wpend_reg   <= 1'b0;
         dir_in_reg  <= 1'b0;
         strb_d_reg  <= 1'b0;
         rst_out_reg <= 1'b0;
      end else begin
         state_reg   <= state_next;
         cnt_reg     <= cnt_next;
         op_reg      <= op_next;
         da_reg      <= da_next;
         cs0_reg     <= cs0_next;
         cs1_reg     <= cs1_next;
         dior_reg    <= dior_next;
         diow_reg    <= diow_next;
         dmack_reg   <= dmack_next;
         dd_out_reg  <= dd_out_next;
         dd_oe_reg   <= dd_oe_next;
         rsp_v_reg   <= rsp_v_next;
         rsp_d_reg   <= rsp_d_next;
         wpend_reg   <= wpend_next;
         dir_in_reg  <= dir_in_next;
         strb_d_reg  <= strb_d_next;
         rst_out_reg <= rst_out_next;
      end
   end

   // Pins and user outputs straight from flops; busy decodes the state flops.
   assign da          = da_reg;
   assign cs0_n       = cs0_reg;
   assign cs1_n       = cs1_reg;
   assign dior_n      = dior_reg;
   assign diow_n      = diow_reg;
   assign dmack_n     = dmack_reg;
   assign dd_out      = dd_out_reg;
   assign dd_oe       = dd_oe_reg;
   assign rsp_valid   = rsp_v_reg;
   assign rsp_data    = rsp_d_reg;
   assign busy        = (state_reg != ST_IDLE);
   assign intrq_level = intrq_s;
   assign dmarq_level = dmarq_s;
   assign storage_controller_reset_n = rst_out_reg;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   AST_BYTE_LANE: assert property ((dd_oe && ahp_is_reg(op_reg) && !busy == 1'b0 &&
      state_reg != ST_URUN) |-> dd_out[15:8] == 8'h00)
      else $error("Register write drives upper data lines.");
   AST_READ_LATCH: assert property ((rsp_valid && !$past(dmack_n == 1'b0)) |->
      (dior_n && $past(dior_n, 2) == 1'b0))
      else $error("PIO read data not taken at strobe rise.");
   AST_IORDY_EXTEND: assert property ((state_reg == ST_STROBE && cnt_reg == 4'h1 &&
      honour && !iordy_s) |=> (state_reg == ST_STROBE && !(dior_n && diow_n)))
      else $error("Strobe released while ready negated.");
   AST_ADDR_STABLE: assert property ((!dior_n || !diow_n) && state_reg == ST_STROBE
      |-> $stable(da) && (cs0_n != cs1_n))
      else $error("Address or chip select moved under strobe.");
   AST_DMACK_CAUSE: assert property ($fell(dmack_n) |-> $past(dmarq_s))
      else $error("DMA acknowledge without request.");
   AST_HDMARDY: assert property ((state_reg == ST_URUN && dir_in_reg) |-> !dior_n && !dmack_n)
      else $error("Host not ready during data-in burst.");
   AST_STOP_SEQ: assert property ((state_reg == ST_URUN && udma_stop) |=>
      (diow_n && !dmack_n) ##1 (diow_n && !dmack_n))
      else $error("Stop not held before acknowledge release.");
   AST_OUT_PACE: assert property ((state_reg == ST_URUN && !dir_in_reg && iordy_s &&
      dmarq_s && !udma_stop) |=> $stable(dior_n))
      else $error("Data-out strobe moved while device paused.");
   AST_RESET_OUT: assert property (dev_reset_req |=> !storage_controller_reset_n)
      else $error("Storage reset not driven.");
   AST_WRITE_HOLD: assert property (($rose(diow_n) && state_reg == ST_RECOV) |->
      dd_oe && $stable(dd_out))
      else $error("Write data removed at strobe rise.");

   COV_PIO_READ: cover property (state_reg == ST_STROBE ##1 rsp_valid);
   COV_PIO_WAIT: cover property (state_reg == ST_STROBE && !iordy_s && honour && cnt_reg == 4'h1);
   COV_UDMA_IN: cover property (state_reg == ST_URUN && dir_in_reg && rsp_valid);
   COV_UDMA_STOP: cover property (state_reg == ST_USTOP ##1 state_reg == ST_IDLE);

endmodule // ahp_port

/* dv/ahp_dev_model.sv */
`timescale 1ns/10ps
// Behavioural storage device on the far side of the host port.
module ahp_dev_model (
   input  wire logic        sys_clk,   // Sampling clock for strobe edges.
   input  wire logic [2:0]  da,        // Register address.
   input  wire logic        cs0_n,     // Chip select 0.
   input  wire logic        cs1_n,     // Chip select 1.
   input  wire logic        dior_n,    // Read strobe.
   input  wire logic        diow_n,    // Write strobe.
   input  wire logic        dmack_n,   // DMA acknowledge.
   input  wire logic        rst_n,     // Controller reset from the host.
   input  wire logic [15:0] dd_out,    // Host data.
   input  wire logic        dd_oe,     // Host drives data.
   input  wire logic [3:0]  stall_cyc, // Ready hold-off per strobe.
   input  wire logic        int_pend,  // Interrupt pending.
   input  wire logic        dma_on,    // DMA command in progress.
   output logic [15:0]      dd_in,     // Data toward the host.
   output logic             iordy,     // Ready, flow control or strobe.
   output logic             intrq,     // Interrupt request.
   output logic             dmarq,     // DMA request.
   output logic [15:0]      out_last,  // Last burst word taken.
   output logic [3:0]       out_cnt    // Burst words taken.
);
   logic [15:0] mem [16];
   logic [15:0] last_reg;
   logic        rd_prev;
   logic        wr_prev;
   logic        strobe_reg;
   logic [3:0]  hold_cnt;
   logic [3:0]  word_cnt;
   logic [3:0]  tick;
   wire  [3:0]  idx       = {cs0_n, da};
   wire         in_burst  = !dmack_n && !dd_oe && !dior_n && dma_on;
   wire         out_burst = !dmack_n && dd_oe;

   // Released lines show the inverse of the last value, so a late latch is caught.
   always_comb begin
      if (in_burst) dd_in = 16'hC000 + 16'(word_cnt);
      else if (!dior_n && dmack_n && !(cs0_n && cs1_n)) dd_in = mem[idx];
      else dd_in = ~last_reg;
      if (out_burst) iordy = 1'b0;
      else if (in_burst) iordy = strobe_reg;
      else iordy = !((!dior_n || !diow_n) && dmack_n && hold_cnt < stall_cyc);
      intrq = int_pend && rst_n;
      dmarq = dma_on && rst_n;
   end

   // Strobe edges are seen on the clock; the host holds them for whole cycles.
   always_ff @(posedge sys_clk) begin
      rd_prev <= dior_n;
      wr_prev <= diow_n;
      last_reg <= rst_n ? dd_in : 16'h0000;
      if (!dior_n || !diow_n) begin
         if (hold_cnt != 4'hF) hold_cnt <= hold_cnt + 4'h1;
      end else hold_cnt <= 4'h0;
      if (wr_prev === 1'b0 && diow_n && dmack_n && !(cs0_n && cs1_n))
         mem[idx] <= dd_oe ? dd_out : ~dd_out;
      if (!rst_n || dmack_n) begin
         strobe_reg <= 1'b1;
         word_cnt <= 4'h0;
         tick <= 4'h0;
      end else if (in_burst) begin
         tick <= (tick == 4'h5) ? 4'h0 : tick + 4'h1;
         if (tick == 4'h5 && word_cnt < 4'h4) begin
            strobe_reg <= !strobe_reg;
            word_cnt <= word_cnt + 4'h1;
         end
      end
      if (!dma_on) out_cnt <= 4'h0;
      else if (out_burst && dior_n !== rd_prev) begin
         out_last <= dd_out;
         out_cnt <= out_cnt + 4'h1;
      end
   end
endmodule // ahp_dev_model

/* dv/test_ata_host_side_port.sv */
`timescale 1ns/10ps
// Self-checking bench for the host-side storage port.
module test_ata_host_side_port;
   import ahp_pkg::*;
   logic        sys_clk, nrst, cmd_valid, cmd_cs1, udma_stop, iordy_en, dev_reset_req;
   logic        cmd_ready, rsp_valid, busy, intrq_level, dmarq_level, cs0_n, cs1_n;
   logic        dior_n, diow_n, dmack_n, storage_controller_reset_n, dd_oe, iordy, intrq;
   logic        dmarq, int_pend, dma_on;
   logic [2:0]  cmd_op, cmd_addr, pio_mode, da;
   logic [3:0]  stall_cyc, out_cnt;
   logic [15:0] cmd_wdata, rsp_data, dd_out, dd_in, out_last, wv [16];
   logic [31:0] rng = 32'hB045;
   logic [15:0] exp_q [$];
   int          fail_count = 0;
   int          n_tests = 0;
   int          lat;

   ahp_port DUT (.sys_clk(sys_clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_cs1(cmd_cs1), .cmd_wdata(cmd_wdata),
      .udma_stop(udma_stop), .pio_mode(pio_mode), .iordy_en(iordy_en),
      .dev_reset_req(dev_reset_req), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .busy(busy),
      .intrq_level(intrq_level), .dmarq_level(dmarq_level), .da(da), .cs0_n(cs0_n),
      .cs1_n(cs1_n), .dior_n(dior_n), .diow_n(diow_n), .dmack_n(dmack_n),
      .storage_controller_reset_n(storage_controller_reset_n), .dd_in(dd_in), .dd_out(dd_out),
      .dd_oe(dd_oe), .iordy(iordy), .intrq(intrq), .dmarq(dmarq));
   ahp_dev_model dev (.sys_clk(sys_clk), .da(da), .cs0_n(cs0_n), .cs1_n(cs1_n), .dior_n(dior_n),
      .diow_n(diow_n), .dmack_n(dmack_n), .rst_n(storage_controller_reset_n), .dd_out(dd_out),
      .dd_oe(dd_oe), .stall_cyc(stall_cyc), .int_pend(int_pend), .dma_on(dma_on),
      .dd_in(dd_in), .iordy(iordy), .intrq(intrq), .dmarq(dmarq), .out_last(out_last),
      .out_cnt(out_cnt));

   // Free-running 25 MHz clock.
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = !sys_clk;
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic results;
      if (fail_count == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Offer a command and hold it until the port takes it; an edge passes before the next offer.
   task automatic cmd(input logic [2:0] op, input logic [2:0] a, input logic c1,
                      input logic [15:0] w);
      int n;
      n = 0;
      cmd_op <= op;
      cmd_addr <= a;
      cmd_cs1 <= c1;
      cmd_wdata <= w;
      cmd_valid <= 1'b1;
      do begin @(posedge sys_clk); n++; end while (cmd_ready !== 1'b1 && n < 400);
      cmd_valid <= 1'b0;
      chk("cmd_ready", 16'h0001, {15'h0, cmd_ready});
      @(posedge sys_clk);
   endtask

   task automatic wait_idle;
      int n;
      n = 0;
      do begin @(posedge sys_clk); n++; end while (busy !== 1'b0 && n < 400);
      chk("busy", 16'h0000, {15'h0, busy});
   endtask

   task automatic rd(input int i, input logic [15:0] e);
      exp_q.push_back(e);
      cmd(i == 0 ? OP_DAT_RD : OP_REG_RD, 3'(i), i[3], 16'h0000);
   endtask

   task automatic lat_rd(input int m, input logic en);
      pio_mode <= 3'(m);
      iordy_en <= en;
      rd(1, {8'h00, wv[1][7:0]});
      lat = 0;
      do begin @(posedge sys_clk); lat++; end while (rsp_valid !== 1'b1 && lat < 100);
      wait_idle;
   endtask

   task automatic chk_idle(input logic [4:0] e);
      chk("idle_pins", {11'h0, e}, {11'h0, cs0_n, cs1_n, dior_n, dd_oe, storage_controller_reset_n});
   endtask

   // The stop line must rise while the acknowledge is still held.
   task automatic stop_burst;
      int n;
      n = 0;
      chk("diow_in_burst", 16'h0000, {15'h0, diow_n});
      udma_stop <= 1'b1;
      do begin @(posedge sys_clk); n++; end while (diow_n !== 1'b1 && n < 50);
      chk("ack_at_stop", 16'h0000, {15'h0, dmack_n});
      wait_idle;
      udma_stop <= 1'b0;
      dma_on <= 1'b0;
      chk("ack_released", 16'h0001, {15'h0, dmack_n});
   endtask

   // Each response takes the oldest expectation.
   always @(posedge sys_clk) begin
      if (rsp_valid === 1'b1) begin
         if (exp_q.size() == 0) chk("rsp_unexpected", 16'h0000, 16'hFFFF);
         else chk("rsp_data", exp_q.pop_front(), rsp_data);
      end
   end

   // Cuts a hang short well beyond the planned run.
   initial begin
      #(40 * 30000);
      fail_count++;
      results;
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      {nrst, cmd_valid, cmd_cs1, udma_stop, iordy_en, dev_reset_req, int_pend, dma_on} = '0;
      {cmd_op, cmd_addr, pio_mode, stall_cyc, cmd_wdata} = '0;
      repeat (16) @(posedge sys_clk);
      chk_idle(5'b11100);
      nrst <= 1'b1;
      @(posedge sys_clk);
      for (int m = 0; m < 5; m++) begin
         pio_mode <= 3'(m);
         for (int i = 0; i < 16; i++) begin
            rng = lfsr_next(rng);
            wv[i] = rng[15:0];
            cmd(i == 0 ? OP_DAT_WR : OP_REG_WR, 3'(i), i[3], wv[i]);
         end
         for (int i = 0; i < 16; i++) rd(i, i == 0 ? wv[i] : {8'h00, wv[i][7:0]});
         wait_idle;
      end
      stall_cyc <= 4'hC;
      lat_rd(4, 1'b0);
      chk("stall_mode4", 16'h0001, 16'(lat >= 12));
      lat_rd(1, 1'b0);
      chk("stall_ignored", 16'h0001, 16'(lat <= 9));
      lat_rd(1, 1'b1);
      chk("stall_honoured", 16'h0001, 16'(lat >= 12));
      stall_cyc <= 4'h0;
      int_pend <= 1'b1;
      repeat (4) @(posedge sys_clk);
      chk("intrq_level", 16'h0001, {15'h0, intrq_level});
      int_pend <= 1'b0;
      dma_on <= 1'b1;
      repeat (4) @(posedge sys_clk);
      chk("intrq_clear", 16'h0000, {15'h0, intrq_level});
      chk("dmarq_level", 16'h0001, {15'h0, dmarq_level});
      for (int k = 1; k < 5; k++) exp_q.push_back(16'hC000 + 16'(k));
      cmd(OP_UDMA_IN, 3'h0, 1'b0, 16'h0000);
      for (int n = 0; n < 200 && exp_q.size() != 0; n++) @(posedge sys_clk);
      chk("udma_in_words", 16'h0000, 16'(exp_q.size()));
      chk("in_ready", 16'h0000, {15'h0, dmack_n, dior_n});
      stop_burst;
      repeat (3) @(posedge sys_clk);
      dma_on <= 1'b1;
      cmd(OP_UDMA_OUT, 3'h0, 1'b0, 16'h0000);
      for (int k = 0; k < 4; k++) begin
         rng = lfsr_next(rng);
         cmd(OP_UDMA_OUT, 3'h0, 1'b0, rng[15:0]);
      end
      for (int n = 0; n < 200 && out_cnt != 4'h4; n++) @(posedge sys_clk);
      chk("out_count", 16'h0004, {12'h0, out_cnt});
      chk("out_last", rng[15:0], out_last);
      stop_burst;
      cmd(OP_DAT_RD, 3'h0, 1'b0, 16'h0000);
      @(posedge sys_clk);
      nrst <= 1'b0;
      @(posedge sys_clk);
      chk_idle(5'b11100);
      nrst <= 1'b1;
      dev_reset_req <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk("reset_out_low", 16'h0000, {15'h0, storage_controller_reset_n});
      dev_reset_req <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk_idle(5'b11101);
      rd(1, {8'h00, wv[1][7:0]});
      wait_idle;
      chk("left_over", 16'h0000, 16'(exp_q.size()));
      results;
   end
endmodule // test_ata_host_side_port
